// ===== include/uif_regs.vh
`ifndef UIF_REGS_VH
`define UIF_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets, per bank
// ----------------------------------------------------------------------------
`define UIF_OFF_DATA 3'h0
`define UIF_OFF_IEN 3'h1
`define UIF_OFF_EVQ 3'h2
`define UIF_OFF_LCB 3'h3
`define UIF_OFF_MDC 3'h4
`define UIF_OFF_LST 3'h5
`define UIF_OFF_MST 3'h6
`define UIF_OFF_SPAD 3'h7
`define UIF_OFF_DIV_LO 3'h0
`define UIF_OFF_DIV_HI 3'h1
`define UIF_OFF_EXT1 3'h2
`define UIF_OFF_EXT2 3'h4
`define UIF_OFF_IRC1 3'h0
`define UIF_OFF_IRC2 3'h1
`define UIF_OFF_IRC3 3'h2
`define UIF_OFF_IRC4 3'h4

// ----------------------------------------------------------------------------
// Banks and field positions
// ----------------------------------------------------------------------------
`define UIF_BANK0 2'h0
`define UIF_BANK1 2'h1
`define UIF_BANK2 2'h2
`define UIF_BANK3 2'h3
`define UIF_EXT1_EXT 0
`define UIF_EXT1_BAUD_TEST 1
`define UIF_EXT1_LOOP 2
`define UIF_EXT2_LOCK 7
`define UIF_IRC4_AUTO 7
`define UIF_IRC4_DIR0 5
`define UIF_IRC4_DIR21 4
`define UIF_IRC4_RX2 3

// ----------------------------------------------------------------------------
// Modes, codes and reset values
// ----------------------------------------------------------------------------
`define UIF_MODE_UART 2'h0
`define UIF_MODE_SIR 2'h1
`define UIF_MODE_HDX 2'h2
`define UIF_MODE_CIR 2'h3
`define UIF_QLVL_16 2'h0
`define UIF_PRESC_13 2'h0
`define UIF_QDEPTH 5'h10
`define UIF_RST_BYTE 8'h00
`define UIF_RST_DIV 16'h000C

`endif

// ===== rtl/uif_ctrl.v
`timescale 1ns/10ps
`include "uif_regs.vh"

module uif_ctrl (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Register port
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata_q,
    // DMA data port
    input wire dma_wr,
    input wire dma_rd,
    input wire [7:0] dma_wdata,
    output reg [7:0] dma_rdata_q,
    // Serial data stream
    input wire rx_push,
    input wire [7:0] rx_byte,
    input wire tx_pop,
    output reg [7:0] tx_byte_q,
    output reg tx_avail_q,
    // Configuration seen by the baud and codec logic
    output reg [15:0] divisor_q,
    output reg [7:0] ext_control_1_q,
    output reg [7:0] ext_control_2_q,
    // Transceiver pins
    input wire [2:0] xcvr_select_pins_in,
    input wire xcvr_id_input,
    output reg [2:0] xcvr_select_pins_out_q,
    output reg [2:0] xcvr_select_pins_oe_q,
    output reg second_ir_receive_q
);

// ----------------------------------------------------------------------------
// State
// ----------------------------------------------------------------------------
reg [1:0] bank_q;
reg [7:0] link_ctrl_q;
reg [7:0] interrupt_enable_reg_q;
reg [7:0] modem_ctrl_q;
reg [7:0] scratch_q;
reg [7:0] lock_pad_lo_q;
reg [7:0] lock_pad_hi_q;
reg [7:0] ir_config_1_q;
reg [7:0] ir_config_2_q;
reg [7:0] ir_config_3_q;
reg [7:0] ir_config_4_q;
reg fen_q;
reg overrun_q;
reg [7:0] txq [0:15];
reg [7:0] rxq [0:15];
reg [3:0] tx_wr_q;
reg [3:0] tx_rd_q;
reg [4:0] tx_cnt_q;
reg [3:0] rx_wr_q;
reg [3:0] rx_rd_q;
reg [4:0] rx_cnt_q;
reg [3:0] pin_meta_q;
reg [3:0] pin_sync_q;

// ----------------------------------------------------------------------------
// Decode
// ----------------------------------------------------------------------------
wire extended_select = ext_control_1_q[`UIF_EXT1_EXT];
wire locked = ext_control_2_q[`UIF_EXT2_LOCK] && !extended_select;
wire [1:0] op_mode = ext_control_1_q[5:4];
wire acc = wr_stb || rd_stb;
wire in_b0 = bank_q == `UIF_BANK0;
wire in_b1 = bank_q == `UIF_BANK1;
wire in_b2 = bank_q == `UIF_BANK2;
wire in_b3 = bank_q == `UIF_BANK3;
wire legacy_div = in_b1 && (addr == `UIF_OFF_DIV_LO || addr == `UIF_OFF_DIV_HI);
// Only the bank 1 ports are checked, so bank 2 divisor traffic is harmless.
wire fallback = acc && legacy_div && !locked;
wire alt_div = in_b2 && (addr == `UIF_OFF_DIV_LO || addr == `UIF_OFF_DIV_HI);
wire div_wr = wr_stb && (alt_div || (legacy_div && !locked));
// In the reset mode the holding register behaves as a one-entry queue.
wire [4:0] cap = fen_q ? `UIF_QDEPTH : 5'h01;
wire cpu_data_wr = wr_stb && in_b0 && addr == `UIF_OFF_DATA;
wire cpu_data_rd = rd_stb && in_b0 && addr == `UIF_OFF_DATA;
wire tx_push = (cpu_data_wr || dma_wr) && tx_cnt_q < cap;
wire tx_take = tx_pop && tx_cnt_q != 5'h00;
wire rx_take = (cpu_data_rd || dma_rd) && rx_cnt_q != 5'h00;
wire rx_put = rx_push && rx_cnt_q < cap;
wire rx_lost = rx_push && rx_cnt_q >= cap;
wire link_state_rd = rd_stb && in_b0 && addr == `UIF_OFF_LST;
wire [7:0] tx_src = cpu_data_wr ? wdata : dma_wdata;
wire [7:0] rx_head = rxq[rx_rd_q];

// ----------------------------------------------------------------------------
// Automatic transceiver select values
// ----------------------------------------------------------------------------
reg [2:0] auto_sel;
always @* begin
    case (op_mode)
        `UIF_MODE_UART: auto_sel = ir_config_2_q[2:0];
        `UIF_MODE_SIR: auto_sel = ir_config_2_q[6:4];
        `UIF_MODE_HDX: auto_sel = ir_config_3_q[2:0];
        default: auto_sel = ir_config_3_q[6:4];
    endcase
end

// ----------------------------------------------------------------------------
// Extended control registers
// ----------------------------------------------------------------------------
reg [7:0] ext_control_1_d;
reg [7:0] ext_control_2_d;
always @* begin
    ext_control_1_d = ext_control_1_q;
    ext_control_2_d = ext_control_2_q;
    if (wr_stb && in_b2 && addr == `UIF_OFF_EXT1) begin
        ext_control_1_d = wdata;
    end
    if (wr_stb && in_b2 && addr == `UIF_OFF_EXT2) begin
        ext_control_2_d = wdata;
    end
    if (fallback) begin
        ext_control_2_d[1:0] = `UIF_QLVL_16;
        ext_control_2_d[3:2] = `UIF_PRESC_13;
        ext_control_1_d[`UIF_EXT1_BAUD_TEST] = 1'b0;
        ext_control_1_d[`UIF_EXT1_LOOP] = 1'b0;
        if (extended_select) begin
            ext_control_1_d[`UIF_EXT1_EXT] = 1'b0;
            if (op_mode != `UIF_MODE_SIR && op_mode != `UIF_MODE_HDX) begin
                ext_control_1_d[5:4] = `UIF_MODE_UART;
            end
        end
    end
end

// ----------------------------------------------------------------------------
// Register writes and side effects
// ----------------------------------------------------------------------------
always @(posedge ref_clk) begin
    if (!rst_b) begin
        bank_q <= `UIF_BANK0;
        link_ctrl_q <= `UIF_RST_BYTE;
        interrupt_enable_reg_q <= `UIF_RST_BYTE;
        modem_ctrl_q <= `UIF_RST_BYTE;
        scratch_q <= `UIF_RST_BYTE;
        lock_pad_lo_q <= `UIF_RST_BYTE;
        lock_pad_hi_q <= `UIF_RST_BYTE;
        ir_config_1_q <= `UIF_RST_BYTE;
        ir_config_2_q <= `UIF_RST_BYTE;
        ir_config_3_q <= `UIF_RST_BYTE;
        ir_config_4_q <= `UIF_RST_BYTE;
        ext_control_1_q <= `UIF_RST_BYTE;
        ext_control_2_q <= `UIF_RST_BYTE;
        divisor_q <= `UIF_RST_DIV;
        fen_q <= 1'b0;
        overrun_q <= 1'b0;
    end else begin
        ext_control_1_q <= ext_control_1_d;
        ext_control_2_q <= ext_control_2_d;
        if (!ext_control_1_d[`UIF_EXT1_EXT]) begin
            interrupt_enable_reg_q[7:4] <= 4'h0;
        end
        if (wr_stb && in_b0 && addr == `UIF_OFF_IEN) begin
            interrupt_enable_reg_q[3:0] <= wdata[3:0];
            if (ext_control_1_d[`UIF_EXT1_EXT]) begin
                interrupt_enable_reg_q[7:4] <= wdata[7:4];
            end
        end
        if (wr_stb && in_b0 && addr == `UIF_OFF_EVQ) begin
            fen_q <= wdata[0];
        end
        if (wr_stb && in_b0 && addr == `UIF_OFF_MDC) begin
            modem_ctrl_q <= wdata;
        end
        if (wr_stb && in_b0 && addr == `UIF_OFF_SPAD) begin
            scratch_q <= wdata;
        end
        if (wr_stb && addr == `UIF_OFF_LCB) begin
            if (wdata[7:6] == 2'h3) begin
                bank_q <= wdata[1:0];
            end else begin
                link_ctrl_q <= wdata;
                bank_q <= wdata[7] ? `UIF_BANK1 : `UIF_BANK0;
            end
        end
        if (div_wr && addr == `UIF_OFF_DIV_LO) begin
            divisor_q[7:0] <= wdata;
        end
        if (div_wr && addr == `UIF_OFF_DIV_HI) begin
            divisor_q[15:8] <= wdata;
        end
        if (wr_stb && legacy_div && locked) begin
            if (addr == `UIF_OFF_DIV_LO) begin
                lock_pad_lo_q <= wdata;
            end else begin
                lock_pad_hi_q <= wdata;
            end
        end
        if (wr_stb && in_b3 && addr == `UIF_OFF_IRC1) begin
            ir_config_1_q <= wdata;
        end
        if (wr_stb && in_b3 && addr == `UIF_OFF_IRC2) begin
            ir_config_2_q <= wdata;
        end
        if (wr_stb && in_b3 && addr == `UIF_OFF_IRC3) begin
            ir_config_3_q <= wdata;
        end
        if (wr_stb && in_b3 && addr == `UIF_OFF_IRC4) begin
            ir_config_4_q <= wdata;
        end
        // A lost byte in the same cycle as the status read stays flagged.
        if (rx_lost) begin
            overrun_q <= 1'b1;
        end else if (link_state_rd) begin
            overrun_q <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------------
// Data queues
// ----------------------------------------------------------------------------
always @(posedge ref_clk) begin
    if (tx_push) begin
        txq[tx_wr_q] <= tx_src;
    end
    if (rx_put) begin
        rxq[rx_wr_q] <= rx_byte;
    end
end

always @(posedge ref_clk) begin
    if (!rst_b) begin
        tx_wr_q <= 4'h0;
        tx_rd_q <= 4'h0;
        tx_cnt_q <= 5'h00;
        rx_wr_q <= 4'h0;
        rx_rd_q <= 4'h0;
        rx_cnt_q <= 5'h00;
        tx_byte_q <= `UIF_RST_BYTE;
        tx_avail_q <= 1'b0;
        dma_rdata_q <= `UIF_RST_BYTE;
    end else begin
        if (tx_push) begin
            tx_wr_q <= tx_wr_q + 4'h1;
        end
        if (tx_take) begin
            tx_rd_q <= tx_rd_q + 4'h1;
        end
        if (tx_push && !tx_take) begin
            tx_cnt_q <= tx_cnt_q + 5'h01;
        end else if (tx_take && !tx_push) begin
            tx_cnt_q <= tx_cnt_q - 5'h01;
        end
        if (rx_put) begin
            rx_wr_q <= rx_wr_q + 4'h1;
        end
        if (rx_take) begin
            rx_rd_q <= rx_rd_q + 4'h1;
        end
        if (rx_put && !rx_take) begin
            rx_cnt_q <= rx_cnt_q + 5'h01;
        end else if (rx_take && !rx_put) begin
            rx_cnt_q <= rx_cnt_q - 5'h01;
        end
        // The sink sees the queue head one cycle late; it pops at most every other cycle.
        tx_avail_q <= tx_cnt_q != 5'h00 && !tx_take;
        tx_byte_q <= tx_take ? txq[tx_rd_q + 4'h1] : txq[tx_rd_q];
        if (dma_rd) begin
            dma_rdata_q <= rx_head;
        end
    end
end

// ----------------------------------------------------------------------------
// Read data
// ----------------------------------------------------------------------------
reg [7:0] rd_mux;
always @* begin
    rd_mux = 8'h00;
    if (addr == `UIF_OFF_LCB) begin
        rd_mux = link_ctrl_q;
    end else if (in_b0 && addr == `UIF_OFF_DATA) begin
        rd_mux = rx_head;
    end else if (in_b0 && addr == `UIF_OFF_IEN) begin
        rd_mux = interrupt_enable_reg_q;
    end else if (in_b0 && addr == `UIF_OFF_EVQ) begin
        rd_mux = {fen_q, fen_q, 5'h00, 1'b1};
    end else if (in_b0 && addr == `UIF_OFF_MDC) begin
        rd_mux = modem_ctrl_q;
    end else if (in_b0 && addr == `UIF_OFF_LST) begin
        rd_mux = {1'b0, tx_cnt_q == 5'h00, tx_cnt_q == 5'h00, 3'h0, overrun_q, rx_cnt_q != 5'h00};
    end else if (in_b0 && addr == `UIF_OFF_MST) begin
        rd_mux = {4'h0, pin_sync_q};
    end else if (in_b0 && addr == `UIF_OFF_SPAD) begin
        rd_mux = scratch_q;
    end else if (legacy_div && locked) begin
        rd_mux = addr == `UIF_OFF_DIV_LO ? lock_pad_lo_q : lock_pad_hi_q;
    end else if ((in_b1 || in_b2) && addr == `UIF_OFF_DIV_LO) begin
        rd_mux = divisor_q[7:0];
    end else if ((in_b1 || in_b2) && addr == `UIF_OFF_DIV_HI) begin
        rd_mux = divisor_q[15:8];
    end else if (in_b2 && addr == `UIF_OFF_EXT1) begin
        rd_mux = ext_control_1_q;
    end else if (in_b2 && addr == `UIF_OFF_EXT2) begin
        rd_mux = ext_control_2_q;
    end else if (in_b3 && addr == `UIF_OFF_IRC1) begin
        rd_mux = ir_config_1_q;
    end else if (in_b3 && addr == `UIF_OFF_IRC2) begin
        rd_mux = ir_config_2_q;
    end else if (in_b3 && addr == `UIF_OFF_IRC3) begin
        rd_mux = ir_config_3_q;
    end else if (in_b3 && addr == `UIF_OFF_IRC4) begin
        rd_mux = ir_config_4_q;
    end
end

always @(posedge ref_clk) begin
    if (!rst_b) begin
        rdata_q <= `UIF_RST_BYTE;
    end else if (rd_stb) begin
        rdata_q <= rd_mux;
    end
end

// ----------------------------------------------------------------------------
// Transceiver pins
// ----------------------------------------------------------------------------
always @(posedge ref_clk) begin
    if (!rst_b) begin
        pin_meta_q <= 4'h0;
        pin_sync_q <= 4'h0;
        xcvr_select_pins_out_q <= 3'h0;
        xcvr_select_pins_oe_q <= 3'h0;
        second_ir_receive_q <= 1'b0;
    end else begin
        pin_meta_q <= {xcvr_id_input, xcvr_select_pins_in};
        pin_sync_q <= pin_meta_q;
        // Auto values track the mode each cycle, so a mode change reaches the pins one cycle after the mode register.
        if (ir_config_4_q[`UIF_IRC4_AUTO]) begin
            xcvr_select_pins_out_q <= auto_sel;
        end else begin
            xcvr_select_pins_out_q <= ir_config_1_q[2:0];
        end
        xcvr_select_pins_oe_q[2:1] <= {2{ir_config_4_q[`UIF_IRC4_DIR21]}};
        xcvr_select_pins_oe_q[0] <= ir_config_4_q[`UIF_IRC4_DIR0] && !ir_config_4_q[`UIF_IRC4_RX2];
        second_ir_receive_q <= ir_config_4_q[`UIF_IRC4_RX2] && pin_sync_q[0];
    end
end

endmodule // uif_ctrl

// ===== testbench/uif_ctrl_properties.sv
`timescale 1ns/10ps
module uif_ctrl_properties (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Register port
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] rdata_q,
    // Configuration and pins
    input wire [15:0] divisor_q,
    input wire [7:0] ext_control_1_q,
    input wire [7:0] ext_control_2_q,
    input wire [2:0] xcvr_select_pins_out_q,
    input wire [2:0] xcvr_select_pins_oe_q,
    input wire second_ir_receive_q
);
    // --------------------------------------------------------------
    // Shadow of bank select and transceiver configuration
    // --------------------------------------------------------------
    logic [1:0] bank_q;
    logic [7:0] irc1_q, irc2_q, irc4_q;
    wire leg = (wr_stb | rd_stb) && bank_q == 2'h1 && addr[2:1] == 2'h0;
    wire ext = ext_control_1_q[0];
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            bank_q <= 2'h0;
            irc1_q <= 8'h00;
            irc2_q <= 8'h00;
            irc4_q <= 8'h00;
        end else if (wr_stb) begin
            if (addr == 3'h3) bank_q <= (wdata[7:6] == 2'h3) ? wdata[1:0] : {1'b0, wdata[7]};
            if (bank_q == 2'h3 && addr == 3'h0) irc1_q <= wdata;
            if (bank_q == 2'h3 && addr == 3'h1) irc2_q <= wdata;
            if (bank_q == 2'h3 && addr == 3'h4) irc4_q <= wdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    reset_vals_a: assert property ($rose(rst_b) |-> divisor_q == 16'h000C && xcvr_select_pins_oe_q == 3'h0
        && ext_control_1_q == 8'h00) else $error("bad values after reset");
    ext_fallback_a: assert property (leg && ext |=> ext_control_1_q[2:0] == 3'h0 && ext_control_2_q[3:0] == 4'h0
        && ext_control_1_q[5:4] == (($past(ext_control_1_q[5:4]) == 2'h3) ? 2'h0 : $past(ext_control_1_q[5:4])))
        else $error("fallback from extended mode wrong");
    nonext_fallback_a: assert property (leg && !ext && !ext_control_2_q[7] |=> ext_control_1_q[2:1] == 2'h0
        && ext_control_2_q[3:0] == 4'h0 && $stable(ext_control_1_q[5:4])) else $error("non-extended fallback wrong");
    lock_scratch_a: assert property (leg && !ext && ext_control_2_q[7] |=> $stable(divisor_q)
        && $stable(ext_control_1_q) && $stable(ext_control_2_q)) else $error("locked access changed settings");
    alt_div_a: assert property (wr_stb && bank_q == 2'h2 && addr == 3'h0 |=> divisor_q[7:0] == $past(wdata)
        && $stable(ext_control_1_q)) else $error("alternate divisor write wrong");
    ier_high_a: assert property (rd_stb && bank_q == 2'h0 && addr == 3'h1 && !ext |=> rdata_q[7:4] == 4'h0)
        else $error("upper enables set outside extended mode");
    pin_dir_a: assert property (xcvr_select_pins_oe_q == {{2{$past(irc4_q[4])}}, $past(irc4_q[5] & !irc4_q[3])})
        else $error("select pin direction wrong");
    manual_out_a: assert property (!$past(irc4_q[7]) |-> (xcvr_select_pins_out_q & xcvr_select_pins_oe_q) ==
        ($past(irc1_q[2:0]) & xcvr_select_pins_oe_q)) else $error("manual select levels wrong");
    auto_out_a: assert property ($past(irc4_q[7]) && !$past(ext_control_1_q[5]) |-> xcvr_select_pins_out_q ==
        ($past(ext_control_1_q[4]) ? $past(irc2_q[6:4]) : $past(irc2_q[2:0]))) else $error("automatic levels wrong");
    second_rx_a: assert property (!$past(irc4_q[3]) |-> !second_ir_receive_q)
        else $error("second receive active while unused");
    cover property (leg && ext);
    cover property (leg && !ext && ext_control_2_q[7]);
    cover property (irc4_q[7] && xcvr_select_pins_oe_q != 3'h0);
endmodule // uif_ctrl_properties

// ===== testbench/uif_xcvr_model.sv
`timescale 1ns/10ps
module uif_xcvr_model #(
    // Identification nibble of the adapter; the value is arbitrary.
    parameter [3:0] ID_CODE = 4'hB
) (
    // Lines driven by the controller
    input wire [2:0] sel_out,
    input wire [2:0] sel_oe,
    // Levels seen by the controller
    output wire [2:0] sel_in,
    output wire id_in
);
    // The adapter drives its identification on every line the controller leaves as input.
    assign sel_in = (sel_oe & sel_out) | (~sel_oe & ID_CODE[2:0]);
    assign id_in = ID_CODE[3];
endmodule // uif_xcvr_model

// ===== testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam [3:0] XID = 4'hB;
    reg ref_clk, rst_b, wr_stb, rd_stb, dma_wr, dma_rd, rx_push, tx_pop;
    reg [2:0] addr;
    reg [7:0] wdata, dma_wdata, rx_byte;
    wire [7:0] rdata_q, dma_rdata_q, tx_byte_q, ext1, ext2;
    wire [15:0] divisor_q;
    wire [2:0] sel_in, sel_out, sel_oe;
    wire tx_avail_q, id_in, rx2;
    integer error_cnt, total_checks, m;
    uif_ctrl DUT (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata_q(rdata_q), .dma_wr(dma_wr), .dma_rd(dma_rd), .dma_wdata(dma_wdata), .dma_rdata_q(dma_rdata_q),
        .rx_push(rx_push), .rx_byte(rx_byte), .tx_pop(tx_pop), .tx_byte_q(tx_byte_q), .tx_avail_q(tx_avail_q),
        .divisor_q(divisor_q), .ext_control_1_q(ext1), .ext_control_2_q(ext2), .xcvr_select_pins_in(sel_in),
        .xcvr_id_input(id_in), .xcvr_select_pins_out_q(sel_out), .xcvr_select_pins_oe_q(sel_oe),
        .second_ir_receive_q(rx2));
    uif_xcvr_model #(.ID_CODE(XID)) u_xcvr (.sel_out(sel_out), .sel_oe(sel_oe), .sel_in(sel_in), .id_in(id_in));
    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task chk(input [23:0] got, input [23:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        @(posedge ref_clk);
        wr_stb <= 1'h0;
        #1;
    endtask
    task rd(input [2:0] a, input [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge ref_clk);
        rd_stb <= 1'h0;
        #1 chk(rdata_q, e);
    endtask
    task bank(input [1:0] b);
        wr(3'h3, {6'h30, b});
    endtask
    task push(input [7:0] b);
        @(posedge ref_clk);
        rx_push <= 1'h1;
        rx_byte <= b;
        @(posedge ref_clk);
        rx_push <= 1'h0;
    endtask
    task dmard(input [7:0] e);
        @(posedge ref_clk);
        dma_rd <= 1'h1;
        @(posedge ref_clk);
        dma_rd <= 1'h0;
        #1 chk(dma_rdata_q, e);
    endtask
    task dmawr(input [7:0] b);
        @(posedge ref_clk);
        dma_wr <= 1'h1;
        dma_wdata <= b;
        @(posedge ref_clk);
        dma_wr <= 1'h0;
    endtask
    // Two edges let a pop clear the flag and the next head settle.
    task txchk(input [7:0] e);
        repeat (2) @(posedge ref_clk);
        #1 chk({tx_avail_q, tx_byte_q}, {1'h1, e});
        @(posedge ref_clk);
        tx_pop <= 1'h1;
        @(posedge ref_clk);
        tx_pop <= 1'h0;
    endtask
    task settle;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        #1;
        chk(divisor_q, 16'h000C);
        chk({sel_oe, ext1}, 11'h000);
        rd(3'h1, 8'h00);
        rd(3'h6, {4'h0, XID});
    endtask
    task t_fallback;
        for (m = 0; m < 4; m = m + 1) begin
            bank(2'h2);
            wr(3'h2, {2'h0, m[1:0], 4'h7});
            wr(3'h4, 8'h0F);
            bank(2'h0);
            wr(3'h1, 8'hF3);
            rd(3'h1, 8'hF3);
            bank(2'h1);
            wr({2'h0, m[0]}, m[0] ? 8'h00 : 8'h0C);
            chk(ext1, {2'h0, (m == 3) ? 2'h0 : m[1:0], 4'h0});
            chk(ext2, 8'h00);
            bank(2'h0);
            rd(3'h1, 8'h03);
        end
        bank(2'h2);
        wr(3'h2, 8'h16);
        wr(3'h4, 8'h0F);
        bank(2'h1);
        rd(3'h0, 8'h0C);
        chk({ext1, ext2}, 16'h1000);
    endtask
    task t_lock;
        bank(2'h2);
        wr(3'h2, 8'h00);
        wr(3'h4, 8'h80);
        bank(2'h1);
        wr(3'h0, 8'h3C);
        wr(3'h1, 8'hC3);
        rd(3'h0, 8'h3C);
        rd(3'h1, 8'hC3);
        chk(divisor_q, 16'h000C);
        bank(2'h2);
        wr(3'h2, 8'h01);
        bank(2'h1);
        wr(3'h0, 8'h0C);
        chk(ext1, 8'h00);
        bank(2'h2);
        wr(3'h4, 8'h00);
        wr(3'h2, 8'h01);
        wr(3'h0, 8'hA5);
        wr(3'h1, 8'h5A);
        chk({divisor_q, ext1}, {16'h5AA5, 8'h01});
        rd(3'h7, 8'h00);
        wr(3'h2, 8'h00);
    endtask
    task t_data;
        bank(2'h0);
        push(8'h11);
        push(8'h12);
        wr(3'h1, 8'h00);
        rd(3'h5, 8'h63);
        rd(3'h5, 8'h61);
        rd(3'h0, 8'h11);
        wr(3'h0, 8'h22);
        txchk(8'h22);
        wr(3'h2, 8'h01);
        rd(3'h2, 8'hC1);
        push(8'h44);
        push(8'h55);
        push(8'h66);
        rd(3'h0, 8'h44);
        bank(2'h2);
        dmard(8'h55);
        dmard(8'h66);
        dmawr(8'h77);
        dmawr(8'h88);
        txchk(8'h77);
        txchk(8'h88);
    endtask
    task t_pins;
        bank(2'h3);
        wr(3'h0, 8'h05);
        wr(3'h4, 8'h30);
        settle;
        chk({sel_oe, sel_out}, 6'h3D);
        wr(3'h1, 8'h62);
        wr(3'h4, 8'hB0);
        settle;
        chk(sel_out, 3'h2);
        bank(2'h2);
        wr(3'h2, 8'h10);
        settle;
        chk(sel_out, 3'h6);
        bank(2'h3);
        wr(3'h4, 8'hB8);
        settle;
        chk({sel_oe, rx2}, 4'hD);
    endtask
    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
    initial begin
        {rst_b, wr_stb, rd_stb, dma_wr, dma_rd, rx_push, tx_pop, addr} = 10'h000;
        {wdata, dma_wdata, rx_byte} = 24'h000000;
        error_cnt = 0;
        total_checks = 0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'h1;
        repeat (2) @(posedge ref_clk);
        t_reset;
        t_fallback;
        t_lock;
        t_data;
        t_pins;
        report_and_stop;
    end
endmodule // testbench
bind uif_ctrl uif_ctrl_properties u_props (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .divisor_q(divisor_q), .ext_control_1_q(ext_control_1_q),
    .ext_control_2_q(ext_control_2_q), .xcvr_select_pins_out_q(xcvr_select_pins_out_q),
    .xcvr_select_pins_oe_q(xcvr_select_pins_oe_q), .second_ir_receive_q(second_ir_receive_q));
